/* File: dv/catb_timebase_ctrl_tb.sv */
// Self-checking bench for the counter array timebase and control block
`timescale 1ns/1ps
module counter_array_timebase_control_tb_top import catb_pkg::*; ;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  typedef struct {
    logic w;
    logic [7:0] a, p, d, e;
    logic h;
  } catb_row_t;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  catb_sfr_req_t sfr = '{addr: CTRL_ADDR, default: '0};
  logic idle = 1'b0, t0 = 1'b0, ein = 1'b1, osc = 1'b0;
  logic [2:0] mev = '0, mie = '0;
  logic [7:0] rd;
  logic [15:0] cnt, c0;
  logic hit, tick, act, irq;
  int n_errors = 0, checks = 0, nt, w;
  // Window of 72 cycles holds whole periods of the clock/12 and clock/4 dividers
  int exp_t [8] = '{6, 18, 8, 8, 72, 2, 0, 0};
  catb_row_t rows [9] = '{
    '{0, MODE_ADDR, PAGE_F, 8'h00, 8'h00, 1}, '{1, CTRL_ADDR, 8'h00, 8'h38, 8'h00, 1},
    '{1, CTRL_ADDR, 8'h05, 8'h07, 8'h07, 1}, '{1, CTRL_ADDR, 8'h05, 8'h00, 8'h00, 1},
    '{1, MODE_ADDR, PAGE_F, 8'h70, 8'h00, 1}, '{1, MODE_ADDR, PAGE_F, 8'h8F, 8'h8F, 1},
    '{1, MODE_ADDR, 8'h03, 8'h00, 8'h00, 0}, '{0, MODE_ADDR, PAGE_F, 8'h00, 8'h8F, 1},
    '{0, 8'hD9, PAGE_F, 8'h00, 8'h00, 0}};
  catb_timebase_ctrl #(.CNT_W(16)) i_catb_timebase_ctrl (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_i(sfr), .sfr_rdata_o(rd),
    .sfr_hit_o(hit), .cpu_idle_i(idle), .timer0_ovf_i(t0),
    .external_count_input_i(ein), .ext_osc_clk_i(osc),
    .module_event_i(mev), .module_irq_enable_i(mie), .count_o(cnt),
    .count_tick_o(tick), .active_o(act), .irq_o(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] p, logic [7:0] d);
    @(negedge clk_i);
    sfr.wr = 1'b1; sfr.addr = a; sfr.page = p; sfr.wdata = d;
    @(negedge clk_i);
    sfr.wr = 1'b0;
  endtask
  task automatic bw(logic [2:0] i, logic v);
    @(negedge clk_i);
    sfr.bit_wr = 1'b1; sfr.bit_idx = i; sfr.bit_val = v; sfr.addr = CTRL_ADDR;
    @(negedge clk_i);
    sfr.bit_wr = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #1600000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    #1;
    chk("ctrl_rst", rd, 8'h00);
    chk("cnt_rst", cnt, 16'h0000);
    chk("irq_rst", irq, 1'b0);
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].p, rows[k].d);
      else begin
        @(negedge clk_i);
        sfr.addr = rows[k].a; sfr.page = rows[k].p;
      end
      #1;
      chk("rdata", rd, rows[k].e);
      chk("hit", hit, rows[k].h);
    end
    for (int c = 0; c < 8; c++) begin
      wr(CTRL_ADDR, 8'h00, 8'h00);
      wr(MODE_ADDR, PAGE_F, {4'h0, c[2:0], 1'b0});
      wr(CTRL_ADDR, 8'h00, 8'h40);
      c0 = cnt; nt = 0;
      // Edges stop 8 cycles early so synchroniser latency stays inside
      for (int y = 0; y < 72; y++) begin
        t0 = (y < 64) && (y % 8 == 0);
        ein = !((y < 64) && (y % 8 >= 4));
        osc = (y < 64) && y[1];
        #1;
        nt += tick;
        @(negedge clk_i);
      end
      chk("ticks", nt, exp_t[c]);
      chk("count", cnt - c0, exp_t[c]);
    end
    wr(MODE_ADDR, PAGE_F, 8'h88);
    idle = 1'b1; c0 = cnt;
    repeat (10) @(negedge clk_i);
    chk("idle_act", act, 1'b0);
    chk("idle_cnt", cnt, c0);
    wr(MODE_ADDR, PAGE_F, 8'h08);
    c0 = cnt;
    repeat (10) @(negedge clk_i);
    chk("idle_run", cnt - c0, 16'd10);
    idle = 1'b0;
    bw(3'd6, 1'b0);
    c0 = cnt;
    repeat (5) @(negedge clk_i);
    chk("stop_cnt", cnt, c0);
    chk("stop_act", act, 1'b0);
    bw(3'd6, 1'b1);
    mev = 3'b010;
    @(negedge clk_i);
    mev = 3'b000;
    #1;
    chk("evt_flag", rd[2:0], 3'b010);
    chk("evt_mask", irq, 1'b0);
    mie = 3'b010;
    repeat (3) @(negedge clk_i);
    chk("evt_hold", rd[2:0], 3'b010);
    chk("evt_irq", irq, 1'b1);
    wr(CTRL_ADDR, 8'h00, 8'h40);
    #1;
    chk("evt_clr", irq, 1'b0);
    mie = 3'b000;
    sfr.addr = CTRL_ADDR;
    // Full wrap takes 65536 cycles at the undivided clock
    for (w = 0; w < 70000 && cnt !== 16'hFFFF; w++) @(negedge clk_i);
    chk("ovf_pre", rd[7], 1'b0);
    @(negedge clk_i);
    chk("ovf_wrap", cnt, 16'h0000);
    chk("ovf_flag", rd[7], 1'b1);
    chk("ovf_mask", irq, 1'b0);
    wr(MODE_ADDR, PAGE_F, 8'h09);
    sfr.addr = CTRL_ADDR;
    repeat (4) @(negedge clk_i);
    chk("ovf_hold", rd[7], 1'b1);
    chk("ovf_irq", irq, 1'b1);
    bw(3'd7, 1'b0);
    #1;
    chk("ovf_clr", rd[7], 1'b0);
    chk("ovf_irq0", irq, 1'b0);
    report_and_stop();
  end
endmodule

/* File: rtl/catb_pkg.sv */
// Package for the counter array timebase and control block
package catb_pkg;
  // ----------------------------------------
  // Special function register addresses
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'hD8;
  localparam logic [7:0] MODE_ADDR = 8'hED;
  localparam logic [7:0] PAGE_F = 8'h0F;
  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int OVF_BIT = 7;
  localparam int RUN_BIT = 6;
  localparam int IDLE_BIT = 7;
  localparam int TB_LSB = 1;
  localparam int OVIE_BIT = 0;
  localparam int NUM_MODULES = 3;
  localparam logic [7:0] CTRL_MASK = 8'hC7;
  localparam logic [7:0] MODE_MASK = 8'h8F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // ----------------------------------------
  // Timebase codes and divider figures
  // ----------------------------------------
  typedef enum logic [2:0] {
    TB_DIV12 = 3'b000,
    TB_DIV4 = 3'b001,
    TB_T0OVF = 3'b010,
    TB_EXTIN = 3'b011,
    TB_SYSCLK = 3'b100,
    TB_EXTCLK8 = 3'b101,
    TB_RSVD6 = 3'b110,
    TB_RSVD7 = 3'b111
  } catb_tb_t;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
  // ----------------------------------------
  // Special function bus request
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_wr;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } catb_sfr_req_t;
endpackage

/* File: rtl/catb_timebase_ctrl.sv */
// Counter array main counter, timebase selection and control registers
`timescale 1ns/1ps
// ----------------------------------------
// Overview of operation
// - Overflow flag sets on a wrap from all ones; only software clears it.
// - A set overflow flag with its enable on raises the shared request.
// - Module event flags set on their events; only software clears them.
// - A set module event flag with its enable on raises the shared request.
// - The counter advances only while the run bit is 1, else it holds.
// - With idle suspend set, counter array operation pauses in CPU idle.
// - Codes 000, 001, 010, 100 pick clock/12, clock/4, timer 0, clock.
// - Code 011 counts falling edges of the external count input.
// - Code 101 counts the external oscillator divided by 8, resynchronised.
// - Unused control and mode bits read as zero and ignore writes.
// - The control register sits at 0xD8 on every page, bit addressable.
// - The mode register sits at 0xED on page F only.
// ----------------------------------------
module catb_timebase_ctrl
  import catb_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire catb_sfr_req_t sfr_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  input wire logic cpu_idle_i,
  input wire logic timer0_ovf_i,
  input wire logic external_count_input_i,
  input wire logic ext_osc_clk_i,
  input wire logic [NUM_MODULES-1:0] module_event_i,
  input wire logic [NUM_MODULES-1:0] module_irq_enable_i,
  output logic [CNT_W-1:0] count_o,
  output logic count_tick_o,
  output logic active_o,
  output logic irq_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ctrl;
  logic [7:0] mode;
  logic [CNT_W-1:0] count;
  logic [3:0] presc;
  logic [2:0] ext_sh;
  logic [2:0] osc_sh;
  logic [2:0] osc_div;
  logic [7:0] next_ctrl;
  logic [7:0] next_mode;
  logic [CNT_W-1:0] next_count;
  logic [3:0] next_presc;
  logic [2:0] next_ext_sh;
  logic [2:0] next_osc_sh;
  logic [2:0] next_osc_div;
  logic ctrl_sel;
  logic mode_sel;
  logic active;
  logic suspended;
  logic tick;
  logic wrap;
  catb_tb_t tb;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign ctrl_sel = (sfr_i.addr == CTRL_ADDR);
  assign mode_sel = (sfr_i.addr == MODE_ADDR)
    && (sfr_i.page == PAGE_F);
  assign tb = catb_tb_t'(mode[TB_LSB +: 3]);
  // Idle suspend freezes flags and counter alike
  assign suspended = mode[IDLE_BIT] && cpu_idle_i;
  assign active = ctrl[RUN_BIT] && !suspended;

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  always_comb begin
    next_ext_sh = {ext_sh[1:0], external_count_input_i};
    // External oscillator taken through two flops before any logic sees it
    next_osc_sh = {osc_sh[1:0], ext_osc_clk_i};
    next_presc = presc;
    next_osc_div = osc_div;
    tick = 1'b0;
    if (active) begin
      case (tb)
        TB_DIV12: begin
          tick = (presc == DIV12_LAST);
          next_presc = tick ? 4'h0 : presc + 4'h1;
        end
        TB_DIV4: begin
          tick = (presc >= DIV4_LAST);
          next_presc = tick ? 4'h0 : presc + 4'h1;
        end
        TB_T0OVF: tick = timer0_ovf_i;
        // Rate limit on the input is the source's duty; no filter here
        TB_EXTIN: tick = ext_sh[2] && !ext_sh[1];
        TB_SYSCLK: tick = 1'b1;
        TB_EXTCLK8: begin
          // Eighth rising edge of the resynchronised oscillator
          if (osc_sh[1] && !osc_sh[2]) begin
            tick = (osc_div == EXT_DIV_LAST);
            next_osc_div = osc_div + 3'h1;
          end
        end
        default: tick = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Counter and registers
  // ----------------------------------------
  always_comb begin
    wrap = tick && (count == CNT_MAX);
    next_count = tick ? count + 1'b1 : count;
    next_ctrl = ctrl;
    next_mode = mode;
    if (sfr_i.wr && ctrl_sel) begin
      next_ctrl = sfr_i.wdata & CTRL_MASK;
    end else if (sfr_i.bit_wr && ctrl_sel) begin
      next_ctrl[sfr_i.bit_idx] = sfr_i.bit_val;
      next_ctrl = next_ctrl & CTRL_MASK;
    end
    if (sfr_i.wr && mode_sel) begin
      next_mode = sfr_i.wdata & MODE_MASK;
    end
    // Hardware set wins over a software clear in the same cycle
    if (wrap) begin
      next_ctrl[OVF_BIT] = 1'b1;
    end
    if (!suspended) begin
      next_ctrl[NUM_MODULES-1:0] = next_ctrl[NUM_MODULES-1:0]
        | module_event_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= REG_RESET;
      mode <= REG_RESET;
      count <= CNT_RESET;
      presc <= 4'h0;
      ext_sh <= 3'h7;
      osc_sh <= 3'h0;
      osc_div <= 3'h0;
    end else begin
      ctrl <= next_ctrl;
      mode <= next_mode;
      count <= next_count;
      presc <= next_presc;
      ext_sh <= next_ext_sh;
      osc_sh <= next_osc_sh;
      osc_div <= next_osc_div;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    sfr_rdata_o = 8'h00;
    if (ctrl_sel) begin
      sfr_rdata_o = ctrl & CTRL_MASK;
    end else if (mode_sel) begin
      sfr_rdata_o = mode & MODE_MASK;
    end
  end
  assign sfr_hit_o = ctrl_sel || mode_sel;
  assign count_o = count;
  assign count_tick_o = tick;
  assign active_o = active;
  assign irq_o = (ctrl[OVF_BIT] && mode[OVIE_BIT])
    || |(ctrl[NUM_MODULES-1:0] & module_irq_enable_i);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ----------------------------------------
  // Flags and requests
  // ----------------------------------------
  a_ovf_on_wrap: assert property (
    (tick && count == CNT_MAX) |=> ctrl[OVF_BIT] && count == CNT_RESET)
    else $error("overflow flag missed on wrap");

  a_ovf_sticky: assert property (
    (ctrl[OVF_BIT] && !(ctrl_sel && (sfr_i.wr || sfr_i.bit_wr)))
    |=> ctrl[OVF_BIT])
    else $error("overflow flag dropped without software");

  a_ovf_clear: assert property (
    (ctrl_sel && sfr_i.wr && !sfr_i.wdata[OVF_BIT] && !wrap)
    |=> !ctrl[OVF_BIT])
    else $error("overflow flag not cleared by software");

  a_ovf_cause: assert property (
    $rose(ctrl[OVF_BIT]) |-> $past(wrap) || $past(ctrl_sel && sfr_i.wr)
      || $past(ctrl_sel && sfr_i.bit_wr))
    else $error("overflow flag set without a wrap");

  a_irq_ovf: assert property (
    (ctrl[OVF_BIT] && mode[OVIE_BIT]) |-> irq_o)
    else $error("overflow request missing");

  a_irq_quiet: assert property (
    (!mode[OVIE_BIT] && ~|(ctrl[2:0] & module_irq_enable_i)) |-> !irq_o)
    else $error("spurious request");

  a_irq_evt: assert property (
    |(ctrl[NUM_MODULES-1:0] & module_irq_enable_i) |-> irq_o)
    else $error("module event request missing");

  a_evt_sets: assert property (
    (!suspended && |module_event_i) |=> |ctrl[NUM_MODULES-1:0])
    else $error("module event flag not set");

  a_evt_each: assert property (
    !suspended |=> (ctrl[NUM_MODULES-1:0] & $past(module_event_i))
      == $past(module_event_i))
    else $error("module event flag missed");

  a_evt_sticky: assert property (
    !(ctrl_sel && (sfr_i.wr || sfr_i.bit_wr)) |=> (ctrl[NUM_MODULES-1:0]
      & $past(ctrl[NUM_MODULES-1:0])) == $past(ctrl[NUM_MODULES-1:0]))
    else $error("module event flag dropped without software");

  a_idle_flags: assert property (
    (suspended && !(ctrl_sel && (sfr_i.wr || sfr_i.bit_wr)))
    |=> $stable(ctrl[NUM_MODULES-1:0]))
    else $error("module event flag moved during idle suspend");

  // ----------------------------------------
  // Counter and timebase
  // ----------------------------------------
  a_hold_stop: assert property (
    !ctrl[RUN_BIT] |=> count == $past(count))
    else $error("counter moved while stopped");

  a_stop_quiet: assert property (
    !ctrl[RUN_BIT] |-> !tick && !active_o)
    else $error("tick while stopped");

  a_idle_pause: assert property (
    (mode[IDLE_BIT] && cpu_idle_i) |-> !tick)
    else $error("tick during idle suspend");

  a_idle_run: assert property (
    (!mode[IDLE_BIT] && ctrl[RUN_BIT]) |-> active_o)
    else $error("counter array halted without idle suspend");

  a_count_step: assert property (
    tick |=> count == CNT_W'($past(count) + 1'b1))
    else $error("counter did not advance by one");

  a_count_hold: assert property (
    !tick |=> $stable(count))
    else $error("counter moved without a tick");

  a_sys_tick: assert property (
    (active && tb == TB_SYSCLK) |-> tick)
    else $error("undivided clock tick missing");

  a_t0_tick: assert property (
    (active && tb == TB_T0OVF) |-> tick == timer0_ovf_i)
    else $error("timer 0 overflow tick mismatch");

  a_rsvd_quiet: assert property (
    (tb == TB_RSVD6 || tb == TB_RSVD7) |-> !tick)
    else $error("tick on a reserved timebase code");

  a_div12_rate: assert property (
    (tick && tb == TB_DIV12) |=> !(tick && tb == TB_DIV12) [*8])
    else $error("divide by twelve too fast");

  a_div4_rate: assert property (
    (tick && tb == TB_DIV4) |=> !(tick && tb == TB_DIV4) [*3])
    else $error("divide by four too fast");

  a_ext_edge: assert property (
    (tick && tb == TB_EXTIN) |-> $past(external_count_input_i, 3)
      && !$past(external_count_input_i, 2))
    else $error("external count tick without a falling edge");

  a_osc_rate: assert property (
    (tick && tb == TB_EXTCLK8) |=> !(tick && tb == TB_EXTCLK8) [*7])
    else $error("divided oscillator tick too fast");

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  a_rsvd_read: assert property (
    ctrl_sel |-> sfr_rdata_o[5:3] == 3'h0)
    else $error("unused bits read nonzero");

  a_ctrl_rsvd: assert property (
    (ctrl & ~CTRL_MASK) == 8'h00)
    else $error("unused control bits set");

  a_mode_rsvd: assert property (
    (mode & ~MODE_MASK) == 8'h00)
    else $error("unused mode bits set");

  a_ctrl_page: assert property (
    (sfr_i.addr == CTRL_ADDR) |-> sfr_hit_o && sfr_rdata_o == ctrl)
    else $error("control register not visible on this page");

  a_bit_run: assert property (
    (ctrl_sel && sfr_i.bit_wr && !sfr_i.wr && sfr_i.bit_idx == 3'(RUN_BIT))
    |=> ctrl[RUN_BIT] == $past(sfr_i.bit_val))
    else $error("bit write to run control lost");

  a_mode_page: assert property (
    (sfr_i.addr == MODE_ADDR && sfr_i.page != PAGE_F) |=> $stable(mode))
    else $error("mode register changed from a wrong page");

  a_mode_write: assert property (
    (mode_sel && sfr_i.wr) |=> mode == ($past(sfr_i.wdata) & MODE_MASK))
    else $error("mode register write lost");

  a_miss_read: assert property (
    !(ctrl_sel || mode_sel) |-> sfr_rdata_o == 8'h00 && !sfr_hit_o)
    else $error("read data on a missed address");
endmodule
